// ---- design/ccp_config_protect.v ----
// Purpose: Charger configuration registers with write protection key,
//          watchdog restart field and thermal regulation status.
// Assumes: Register port is driven by the device's serial interface
//          logic, one access per cycle, synchronous to clk_in.
// Notes:   Rule summary follows.
// Operation
// R1: Writing 11 to the key field unlocks the gated registers and any
//     other value locks them again.
// R2: The charge voltage and thermal regulation registers accept writes
//     only while unlocked.
// R3: The key field resets to zero so the gated registers start locked.
// R4: With the watchdog enabled, only a write of 01 to the clear field
//     restarts the watchdog timer.
// R5: The termination code decodes from 3.650 V in 25 mV steps to
//     4.700 V with codes 0x1C and 0x1D at 4.340 V and 4.350 V, reset 0x16.
// R6: The primary termination voltage applies while the charger is
//     enabled and the battery is below the warm threshold.
// R7: The minimum system code decodes to 3.4 V through 3.7 V, reset 2.
// R8: Junction temperature above the setpoint sets the regulation flag
//     and requests current foldback.
// R9: The setpoint code decodes to 85, 100, 115 and 130 C, reset 10.
// R10: The key and watchdog clear register is always writable.
// R11: Reserved bits read their reset values and writes there do nothing.
`timescale 1ns/1ns
`default_nettype none
`include "ccp_regs.vh"

module ccp_config_protect (
   input  wire        clk_in,
   input  wire        arst_n_in,
   // Register port.
   input  wire [7:0]  reg_addr_in,
   input  wire        reg_wr_in,
   input  wire [7:0]  reg_wdata_in,
   input  wire        reg_rd_in,
   output reg  [7:0]  reg_rdata_out,
   output reg         write_refused_out,
   // Charger state from the analog side.
   input  wire        charger_enable_in,
   input  wire        battery_below_warm_in,
   input  wire        watchdog_enable_in,
   input  wire [7:0]  junction_temp_in,
   // Targets and status toward the analog side.
   output reg  [12:0] termination_mv_out,
   output reg         termination_apply_out,
   output reg  [12:0] min_system_mv_out,
   output reg  [7:0]  thermal_setpoint_c_out,
   output reg         thermal_regulation_flag_out,
   output reg         current_foldback_out,
   output reg         watchdog_restart_out,
   output reg         unlocked_out
);

   ////////////////////////////////////////////////////////////////////////
   // Stored fields. Only meaningful bits have flip-flops; reserved
   // positions are constants on readback.
   reg [5:0] termination_voltage_code;
   reg [1:0] min_system_voltage_code;
   reg [1:0] watchdog_clear_field;
   reg [1:0] protection_key_field;
   reg [1:0] thermal_setpoint_code;

   wire        unlocked;
   wire        hit_charge_voltage;
   wire        hit_protect_kick;
   wire        hit_thermal_reg;
   wire        wr_charge_voltage;
   wire        wr_protect_kick;
   wire        wr_thermal_reg;
   wire        gated_write;
   wire [12:0] term_mv;
   wire [12:0] minsys_mv;
   wire [7:0]  setpoint_c;
   wire        over_setpoint;
   reg  [7:0]  next_rdata;

   ////////////////////////////////////////////////////////////////////////
   // Address decode and write qualification. The lock is read from the
   // stored key, so a relock takes effect on the very next access.
   assign unlocked = (protection_key_field == `CCP_KEY_UNLOCK); // R1
   assign hit_charge_voltage = (reg_addr_in == `CCP_OFS_CHARGE_VOLTAGE);
   assign hit_protect_kick   = (reg_addr_in == `CCP_OFS_PROTECT_KICK);
   assign hit_thermal_reg    = (reg_addr_in == `CCP_OFS_THERMAL_REG);
   assign gated_write = reg_wr_in & (hit_charge_voltage | hit_thermal_reg);
   assign wr_charge_voltage = reg_wr_in & hit_charge_voltage & unlocked; // R2
   assign wr_thermal_reg    = reg_wr_in & hit_thermal_reg & unlocked; // R2
   // The key register ignores the lock, otherwise software could never
   // unlock once locked.
   assign wr_protect_kick   = reg_wr_in & hit_protect_kick; // R10

   ////////////////////////////////////////////////////////////////////////
   // Charge voltage register: termination and minimum system codes.
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         termination_voltage_code <= `CCP_RST_TERM_CODE; // R5
         min_system_voltage_code  <= `CCP_RST_MINSYS_CODE; // R7
      end else if (wr_charge_voltage) begin
         termination_voltage_code <=
            reg_wdata_in[`CCP_TERM_MSB:`CCP_TERM_LSB];
         min_system_voltage_code  <=
            reg_wdata_in[`CCP_MINSYS_MSB:`CCP_MINSYS_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Key and watchdog clear register. Any write that is not the unlock
   // code relocks, including a write meant only to kick the watchdog,
   // so software must rewrite 11 alongside a kick to stay unlocked.
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         protection_key_field <= `CCP_RST_KEY; // R3
         watchdog_clear_field <= `CCP_RST_WDCLR;
      end else if (wr_protect_kick) begin
         protection_key_field <=
            reg_wdata_in[`CCP_KEY_MSB:`CCP_KEY_LSB]; // R1
         watchdog_clear_field <=
            reg_wdata_in[`CCP_WDCLR_MSB:`CCP_WDCLR_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Thermal regulation register: only the setpoint is stored.
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         thermal_setpoint_code <= `CCP_RST_SETPOINT_CODE; // R9
      end else if (wr_thermal_reg) begin
         thermal_setpoint_code <=
            reg_wdata_in[`CCP_SETPOINT_MSB:`CCP_SETPOINT_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog restart: a one-cycle pulse toward the watchdog timer. The
   // codes 00, 10 and 11 are stored but restart nothing.
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         watchdog_restart_out <= 1'b0;
      end else begin
         watchdog_restart_out <= wr_protect_kick & watchdog_enable_in
            & (reg_wdata_in[`CCP_WDCLR_MSB:`CCP_WDCLR_LSB]
               == `CCP_WDCLR_KICK); // R4
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // A write aimed at a gated register while locked is dropped; the
   // pulse lets the interface logic report it if it wishes.
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         write_refused_out <= 1'b0;
      end else begin
         write_refused_out <= gated_write & ~unlocked; // R2
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoders. Kept apart so the analog targets can be retargeted
   // without touching the protection logic.
   ccp_volt_decode u_volt_decode (
      .term_code_in   (termination_voltage_code),
      .minsys_code_in (min_system_voltage_code),
      .term_mv_out    (term_mv),
      .minsys_mv_out  (minsys_mv)
   );

   ccp_thermal_mon u_thermal_mon (
      .setpoint_code_in  (thermal_setpoint_code),
      .junction_temp_in  (junction_temp_in),
      .setpoint_c_out    (setpoint_c),
      .over_setpoint_out (over_setpoint)
   );

   ////////////////////////////////////////////////////////////////////////
   // Registered targets. One cycle of lag after a register write is far
   // below any analog loop's response time and keeps outputs glitch free.
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         termination_mv_out     <= `CCP_TERM_BASE_MV;
         min_system_mv_out      <= `CCP_MINSYS_BASE_MV;
         thermal_setpoint_c_out <= `CCP_SETPOINT_BASE_C;
         termination_apply_out  <= 1'b0;
         unlocked_out           <= 1'b0;
      end else begin
         termination_mv_out     <= term_mv; // R5
         min_system_mv_out      <= minsys_mv; // R7
         thermal_setpoint_c_out <= setpoint_c; // R9
         // The primary target is only in force below the warm threshold;
         // above it another setting, outside this group, takes over.
         termination_apply_out  <=
            charger_enable_in & battery_below_warm_in; // R6
         unlocked_out           <= unlocked;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Thermal regulation: the flag follows the comparison and the same
   // condition asks the current loop to fold back.
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         thermal_regulation_flag_out <= 1'b0;
         current_foldback_out        <= 1'b0;
      end else begin
         thermal_regulation_flag_out <= over_setpoint; // R8
         current_foldback_out        <= over_setpoint; // R8
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux. Reserved positions return their reset value of zero and
   // unmapped addresses read as zero.
   always @* begin
      next_rdata = 8'h00;
      case (reg_addr_in)
         `CCP_OFS_CHARGE_VOLTAGE: begin
            next_rdata = {min_system_voltage_code,
                          termination_voltage_code};
         end
         `CCP_OFS_PROTECT_KICK: begin
            next_rdata = {4'h0, protection_key_field,
                          watchdog_clear_field}; // R11
         end
         `CCP_OFS_THERMAL_REG: begin
            next_rdata = {1'b0, thermal_setpoint_code, 5'h00}; // R11
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // Read data is captured on the read strobe and held until the next.
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= next_rdata;
      end
   end

endmodule
`default_nettype wire

// ---- design/ccp_regs.vh ----
// Purpose: Offsets, field positions, reset values and decode constants
//          of the charger configuration and protection register group.
// Assumes: 8-bit registers on the device's internal register port.
// Notes:   Included by every design file of the group.
`ifndef CCP_REGS_VH
`define CCP_REGS_VH

// Register offsets.
`define CCP_OFS_CHARGE_VOLTAGE   8'hbb
`define CCP_OFS_PROTECT_KICK     8'hbd
`define CCP_OFS_THERMAL_REG      8'hbe

// Reset values.
`define CCP_RST_CHARGE_VOLTAGE   8'h96
`define CCP_RST_PROTECT_KICK     8'h00
`define CCP_RST_THERMAL_REG      8'h40
`define CCP_RST_TERM_CODE        6'h16
`define CCP_RST_MINSYS_CODE      2'h2
`define CCP_RST_WDCLR            2'h0
`define CCP_RST_KEY              2'h0
`define CCP_RST_SETPOINT_CODE    2'h2

// Field positions.
`define CCP_TERM_MSB             5
`define CCP_TERM_LSB             0
`define CCP_MINSYS_MSB           7
`define CCP_MINSYS_LSB           6
`define CCP_WDCLR_MSB            1
`define CCP_WDCLR_LSB            0
`define CCP_KEY_MSB              3
`define CCP_KEY_LSB              2
`define CCP_SETPOINT_MSB         6
`define CCP_SETPOINT_LSB         5

// Field codes with a meaning of their own.
`define CCP_KEY_UNLOCK           2'h3
`define CCP_WDCLR_KICK           2'h1

// Termination voltage decode, millivolts.
`define CCP_TERM_BASE_MV         13'h0e42
`define CCP_TERM_STEP_MV         13'h0019
`define CCP_TERM_LOW_LAST        6'h1b
`define CCP_TERM_EXC_A           6'h1c
`define CCP_TERM_EXC_A_MV        13'h10f4
`define CCP_TERM_EXC_B           6'h1d
`define CCP_TERM_EXC_B_MV        13'h10fe
`define CCP_TERM_HIGH_FIRST      6'h1e
`define CCP_TERM_HIGH_BASE_MV    13'h1117
`define CCP_TERM_TOP             6'h2b
`define CCP_TERM_TOP_MV          13'h125c

// Minimum system voltage decode, millivolts.
`define CCP_MINSYS_BASE_MV       13'h0d48
`define CCP_MINSYS_STEP_MV       13'h0064

// Thermal setpoint decode, degrees Celsius.
`define CCP_SETPOINT_BASE_C      8'h55
`define CCP_SETPOINT_STEP_C      8'h0f

`endif

// ---- design/ccp_thermal_mon.v ----
// Purpose: Decodes the junction regulation setpoint and compares the
//          junction temperature against it.
// Assumes: Temperature arrives as unsigned whole degrees Celsius.
// Notes:   Combinational; the top registers flag and foldback request.
`timescale 1ns/1ns
`default_nettype none
`include "ccp_regs.vh"

module ccp_thermal_mon (
   input  wire [1:0] setpoint_code_in,
   input  wire [7:0] junction_temp_in,
   output reg  [7:0] setpoint_c_out,
   output reg        over_setpoint_out
);

   ////////////////////////////////////////////////////////////////////////
   // Setpoint in fifteen-degree steps, then a strict comparison: at the
   // setpoint itself no foldback is asked for.
   always @* begin
      setpoint_c_out = `CCP_SETPOINT_BASE_C
                     + `CCP_SETPOINT_STEP_C * {6'h00, setpoint_code_in}; // R9
      over_setpoint_out = (junction_temp_in > setpoint_c_out); // R8
   end

endmodule
`default_nettype wire

// ---- design/ccp_volt_decode.v ----
// Purpose: Turns the termination and minimum system voltage codes into
//          millivolt targets for the analog loops.
// Assumes: Codes come from registered configuration fields.
// Notes:   Purely combinational; the top registers the results.
`timescale 1ns/1ns
`default_nettype none
`include "ccp_regs.vh"

module ccp_volt_decode (
   input  wire [5:0]  term_code_in,
   input  wire [1:0]  minsys_code_in,
   output reg  [12:0] term_mv_out,
   output reg  [12:0] minsys_mv_out
);

   ////////////////////////////////////////////////////////////////////////
   // Termination voltage: two linear runs split by two odd codes.
   // Codes past the top of the table clamp to the highest target, so a
   // stray write can never ask for more than the top voltage.
   always @* begin
      if (term_code_in <= `CCP_TERM_LOW_LAST) begin
         term_mv_out = `CCP_TERM_BASE_MV
                     + `CCP_TERM_STEP_MV * {7'h00, term_code_in}; // R5
      end else if (term_code_in == `CCP_TERM_EXC_A) begin
         term_mv_out = `CCP_TERM_EXC_A_MV; // R5
      end else if (term_code_in == `CCP_TERM_EXC_B) begin
         term_mv_out = `CCP_TERM_EXC_B_MV; // R5
      end else if (term_code_in <= `CCP_TERM_TOP) begin
         term_mv_out = `CCP_TERM_HIGH_BASE_MV + `CCP_TERM_STEP_MV
                     * {7'h00, term_code_in - `CCP_TERM_HIGH_FIRST}; // R5
      end else begin
         term_mv_out = `CCP_TERM_TOP_MV;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Minimum system voltage: four codes in three equal 100 mV steps.
   always @* begin
      minsys_mv_out = `CCP_MINSYS_BASE_MV
                    + `CCP_MINSYS_STEP_MV * {11'h000, minsys_code_in}; // R7
   end

endmodule
`default_nettype wire

// ---- verification/ccp_config_protect_props.sv ----
// Purpose: Concurrent checks on the configuration register group ports.
// Assumes: Sees only the ports of ccp_config_protect.
// Notes:   Mirrors the key register nibble to judge lock and readback.
`timescale 1ns/1ns
`default_nettype none
`include "ccp_regs.vh"

module ccp_config_protect_props (
   input wire logic        clk_in,
   input wire logic        arst_n_in,
   input wire logic [7:0]  reg_addr_in,
   input wire logic        reg_wr_in,
   input wire logic [7:0]  reg_wdata_in,
   input wire logic        reg_rd_in,
   input wire logic [7:0]  reg_rdata_out,
   input wire logic        write_refused_out,
   input wire logic        charger_enable_in,
   input wire logic        battery_below_warm_in,
   input wire logic        watchdog_enable_in,
   input wire logic [7:0]  junction_temp_in,
   input wire logic [12:0] termination_mv_out,
   input wire logic        termination_apply_out,
   input wire logic [12:0] min_system_mv_out,
   input wire logic [7:0]  thermal_setpoint_c_out,
   input wire logic        thermal_regulation_flag_out,
   input wire logic        current_foldback_out,
   input wire logic        watchdog_restart_out,
   input wire logic        unlocked_out
);
   default clocking ck @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   ////////////////////////////////////////////////////////////////////////
   logic [3:0] key_kick;
   logic       key_wr;
   logic       gated_wr;
   logic       kick;

   // Decoded strobes; the reserved upper nibble is never mirrored.
   assign key_wr   = reg_wr_in && reg_addr_in == `CCP_OFS_PROTECT_KICK;
   assign gated_wr = reg_wr_in && (reg_addr_in == `CCP_OFS_CHARGE_VOLTAGE ||
                                   reg_addr_in == `CCP_OFS_THERMAL_REG);
   assign kick     = key_wr && reg_wdata_in[1:0] == `CCP_WDCLR_KICK &&
                     watchdog_enable_in;

   // Mirror of the key register, kept so the lock state is known exactly.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         key_kick <= 4'h0;
      end else if (key_wr) begin
         key_kick <= reg_wdata_in[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_refuse_locked: assert property (1'b1 |=> write_refused_out ==
      $past(gated_wr && key_kick[3:2] != `CCP_KEY_UNLOCK))
      else $error("refusal pulse disagrees with lock state");
   a_unlock_lag: assert property (1'b1 |=> unlocked_out ==
      $past(key_kick[3:2] == `CCP_KEY_UNLOCK))
      else $error("unlocked level disagrees with stored key");
   a_kick_pulse: assert property (kick |=> watchdog_restart_out)
      else $error("watchdog restart missing");
   a_no_kick: assert property (!kick |=> !watchdog_restart_out)
      else $error("unexpected watchdog restart");
   a_key_readback: assert property (reg_rd_in && reg_addr_in ==
      `CCP_OFS_PROTECT_KICK |=> reg_rdata_out == {4'h0, $past(key_kick)})
      else $error("key register readback wrong");
   a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without a read");
   a_flag_compare: assert property (1'b1 |=>
      thermal_regulation_flag_out ==
      ($past(junction_temp_in) > thermal_setpoint_c_out))
      else $error("regulation flag disagrees with setpoint");
   a_foldback_flag: assert property (current_foldback_out ==
      thermal_regulation_flag_out)
      else $error("foldback request differs from flag");
   a_apply_follow: assert property (1'b1 |=> termination_apply_out ==
      $past(charger_enable_in && battery_below_warm_in))
      else $error("termination apply level wrong");
endmodule

bind ccp_config_protect ccp_config_protect_props props_u (
   .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
   .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .write_refused_out(write_refused_out),
   .charger_enable_in(charger_enable_in),
   .battery_below_warm_in(battery_below_warm_in),
   .watchdog_enable_in(watchdog_enable_in),
   .junction_temp_in(junction_temp_in),
   .termination_mv_out(termination_mv_out),
   .termination_apply_out(termination_apply_out),
   .min_system_mv_out(min_system_mv_out),
   .thermal_setpoint_c_out(thermal_setpoint_c_out),
   .thermal_regulation_flag_out(thermal_regulation_flag_out),
   .current_foldback_out(current_foldback_out),
   .watchdog_restart_out(watchdog_restart_out),
   .unlocked_out(unlocked_out));
`default_nettype wire

// ---- verification/ccp_config_protect_test.sv ----
// Purpose: Self-checking bench for the configuration register group.
// Assumes: Inputs change on the falling clock edge only.
// Notes:   Table rows cover decodes; hand tests cover lock, kick, reset.
`timescale 1ns/1ns
`default_nettype none

module ccp_config_protect_test;
   typedef struct {
      logic [7:0]  addr, wdata, rexp, sp;
      logic [12:0] tmv, smv;
   } ccp_row_t;
   logic        clk_in = 1'b0, arst_n_in = 1'b0;
   logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic        charger_enable_in = 1'b0, battery_below_warm_in = 1'b0;
   logic        watchdog_enable_in = 1'b0;
   logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
   logic [7:0]  junction_temp_in = 8'h19;
   logic [7:0]  reg_rdata_out, thermal_setpoint_c_out;
   logic [12:0] termination_mv_out, min_system_mv_out;
   logic        write_refused_out, termination_apply_out, unlocked_out;
   logic        thermal_regulation_flag_out, current_foldback_out;
   logic        watchdog_restart_out, refused, kicked;
   int          mismatches = 0, n_checks = 0;
   // Address, write data, readback, setpoint degC, mV targets.
   ccp_row_t rows [15] = '{
      '{8'hbd, 8'h0c, 8'h0c, 8'h73, 13'h1068, 13'h0e10},
      '{8'hbb, 8'h00, 8'h00, 8'h73, 13'h0e42, 13'h0d48},
      '{8'hbb, 8'h5b, 8'h5b, 8'h73, 13'h10e5, 13'h0dac},
      '{8'hbb, 8'h9c, 8'h9c, 8'h73, 13'h10f4, 13'h0e10},
      '{8'hbb, 8'hdd, 8'hdd, 8'h73, 13'h10fe, 13'h0e74},
      '{8'hbb, 8'h1e, 8'h1e, 8'h73, 13'h1117, 13'h0d48},
      '{8'hbb, 8'h2b, 8'h2b, 8'h73, 13'h125c, 13'h0d48},
      '{8'hbe, 8'h00, 8'h00, 8'h55, 13'h125c, 13'h0d48},
      '{8'hbe, 8'h3f, 8'h20, 8'h64, 13'h125c, 13'h0d48},
      '{8'hbe, 8'hc0, 8'h40, 8'h73, 13'h125c, 13'h0d48},
      '{8'hbe, 8'hff, 8'h60, 8'h82, 13'h125c, 13'h0d48},
      '{8'hbd, 8'hf7, 8'h07, 8'h82, 13'h125c, 13'h0d48},
      '{8'hbb, 8'h16, 8'h2b, 8'h82, 13'h125c, 13'h0d48},
      '{8'hbe, 8'h40, 8'h60, 8'h82, 13'h125c, 13'h0d48},
      '{8'h55, 8'hff, 8'h00, 8'h82, 13'h125c, 13'h0d48}};

   ccp_config_protect dut_u (.*);

   ////////////////////////////////////////////////////////////////////////
   // Free-running 100 MHz clock.
   always #5 clk_in = ~clk_in;

   task automatic results;
      if (mismatches == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [12:0] got, input logic [12:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask

   // One write cycle; the pulses it causes are caught one cycle later.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
      refused = write_refused_out;
      kicked = watchdog_restart_out;
   endtask

   // Read and compare; data is valid one cycle after the read edge.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge clk_in);
      reg_rd_in = 1'b0;
      chk_val({5'h00, reg_rdata_out}, {5'h00, exp});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Cuts a hang short; the whole run needs well under 3 us.
   initial begin
      #20000;
      mismatches++;
      results();
   end

   initial begin
      repeat (5) @(negedge clk_in);
      arst_n_in = 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].rexp);
         @(negedge clk_in);
         chk_val(termination_mv_out, rows[i].tmv);
         chk_val(min_system_mv_out, rows[i].smv);
         chk_val({5'h00, thermal_setpoint_c_out}, {5'h00, rows[i].sp});
      end
      wr(8'hbb, 8'h00);
      chk_bit(refused, 1'b1);
      watchdog_enable_in = 1'b1;
      for (int k = 0; k < 4; k++) begin
         wr(8'hbd, {6'h00, k[1:0]});
         chk_bit(kicked, k == 1);
      end
      watchdog_enable_in = 1'b0;
      wr(8'hbd, 8'h01);
      chk_bit(kicked, 1'b0);
      // Unlock and gated write back to back, as fast as the port allows.
      @(negedge clk_in);
      reg_addr_in = 8'hbd;
      reg_wdata_in = 8'h0c;
      reg_wr_in = 1'b1;
      @(negedge clk_in);
      reg_addr_in = 8'hbb;
      reg_wdata_in = 8'h16;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
      chk_bit(write_refused_out, 1'b0);
      chk_bit(unlocked_out, 1'b1);
      rd(8'hbb, 8'h16);
      wr(8'hbe, 8'h00);
      chk_bit(refused, 1'b0);
      wr(8'hbd, 8'h08);
      wr(8'hbe, 8'h60);
      chk_bit(refused, 1'b1);
      // Setpoint is 85 degC; equal must not trip, one above must.
      for (int t = 85; t < 87; t++) begin
         junction_temp_in = t[7:0];
         @(negedge clk_in);
         chk_bit(thermal_regulation_flag_out, t == 86);
         chk_bit(current_foldback_out, t == 86);
      end
      for (int j = 0; j < 4; j++) begin
         {charger_enable_in, battery_below_warm_in} = j[1:0];
         @(negedge clk_in);
         chk_bit(termination_apply_out, j == 3);
      end
      // Second reset in mid-run while locked, one cycle after the apply inputs last changed.
      arst_n_in = 1'b0;
      @(negedge clk_in);
      chk_bit(unlocked_out, 1'b0);
      arst_n_in = 1'b1;
      rd(8'hbb, 8'h96);
      rd(8'hbd, 8'h00);
      rd(8'hbe, 8'h40);
      chk_val(termination_mv_out, 13'h1068);
      chk_val({5'h00, thermal_setpoint_c_out}, 13'h0073);
      wr(8'hbb, 8'h00);
      chk_bit(refused, 1'b1);
      results();
   end
endmodule
`default_nettype wire
